// >>> design/data_injection_module.sv
// Device end: link receiver, word assembler, write FIFO and memory write master.
`default_nettype none

// Synchronous FIFO with valid and ready on both sides.
module inject_fifo #(
  parameter int WIDTH = 65,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  // Storage words.
  logic [WIDTH-1:0] mem [DEPTH];
  // Pointers with one wrap bit to tell full from empty.
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] rd_ptr_reg;
  logic push;
  logic pop;

  // Full when the pointers differ only in the wrap bit.
  assign in_ready = !((wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                      (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]));
  // Empty when the pointers match.
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data = mem[rd_ptr_reg[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Write side.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
    end
    else if (push)
    begin
      mem[wr_ptr_reg[PW-1:0]] <= in_data;
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  // Read side.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_ptr_reg <= '0;
    end
    else if (pop)
    begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule // inject_fifo

// Receives frames on the shared pins and writes them into memory.
module data_injection_module #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  injector_if.device link,
  input wire injector_pkg::lane_cfg_e lane_cfg,
  input wire injector_pkg::inject_mode_e mode,
  input wire logic [injector_pkg::ADDR_W-1:0] base_addr,
  output logic main_wr_valid,
  input wire logic main_wr_ready,
  output logic sig_wr_valid,
  input wire logic sig_wr_ready,
  output logic [injector_pkg::ADDR_W-1:0] wr_addr,
  output logic [injector_pkg::WORD_W-1:0] wr_data,
  output logic overflow
);
  localparam int EW = injector_pkg::ADDR_W + injector_pkg::WORD_W + 1;
  // Two-stage synchronisers for every pin.
  logic [injector_pkg::MAX_LANES+2:0] meta_reg;
  logic [injector_pkg::MAX_LANES+2:0] pin_reg;
  // Previous synchronised link clock, for edge finding.
  logic lclk_prev_reg;
  logic fall;
  logic s_lclk;
  logic s_sync;
  logic s_path;
  logic [injector_pkg::MAX_LANES-1:0] s_data;
  // Word assembly state.
  logic [injector_pkg::WORD_W-1:0] shift_reg;
  logic [injector_pkg::WORD_W-1:0] shift_next;
  logic [injector_pkg::CNT_W-1:0] bits_reg;
  logic [injector_pkg::CNT_W-1:0] bits_next;
  logic [injector_pkg::CNT_W-1:0] lanes;
  logic word_done;
  // High while a frame is open, so its first edge can load the base address.
  logic open_reg;
  // Trace mode: high once the address word of a packet is held.
  logic have_addr_reg;
  logic [injector_pkg::ADDR_W-1:0] pkt_addr_reg;
  // Direct mode address counter.
  logic [injector_pkg::ADDR_W-1:0] addr_ctr_reg;
  // FIFO hookup.
  logic push_valid;
  logic push_ready;
  logic [EW-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [EW-1:0] pop_data;

  // Pins pass two flip-flops before any logic sees them.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      pin_reg <= '0;
    end
    else
    begin
      meta_reg <= {link.path_sel, link.lclk, link.sync, link.data};
      pin_reg <= meta_reg;
    end
  end

  assign s_data = pin_reg[injector_pkg::MAX_LANES-1:0];
  assign s_sync = pin_reg[injector_pkg::MAX_LANES];
  assign s_lclk = pin_reg[injector_pkg::MAX_LANES+1];
  assign s_path = pin_reg[injector_pkg::MAX_LANES+2];

  // Remembers the last link clock level to find its falling edges.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lclk_prev_reg <= 1'b0;
    end
    else
    begin
      lclk_prev_reg <= s_lclk;
    end
  end

  // Sync and data are taken only at a falling link clock edge.
  assign fall = lclk_prev_reg && !s_lclk; // see R6

  // Shifts in the configured number of lanes, first bit most significant.
  always_comb
  begin
    lanes = injector_pkg::lane_count(lane_cfg); // see R4
    shift_next = shift_reg;
    unique case (lane_cfg)
      injector_pkg::LANES_1: shift_next = {shift_reg[30:0], s_data[0]};
      injector_pkg::LANES_2: shift_next = {shift_reg[29:0], s_data[1:0]};
      injector_pkg::LANES_4: shift_next = {shift_reg[27:0], s_data[3:0]};
      injector_pkg::LANES_8: shift_next = {shift_reg[23:0], s_data[7:0]};
    endcase
    bits_next = bits_reg + lanes;
  end

  // A word is complete only when all its bits have arrived.
  assign word_done = fall && s_sync && (bits_next == injector_pkg::WORD_BITS); // see R9

  // Assembly register, bit counter and frame flag; a frame end discards a partial word.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shift_reg <= '0;
      bits_reg <= '0;
      open_reg <= 1'b0;
    end
    else if (fall)
    begin
      if (!s_sync)
      begin
        bits_reg <= '0; // see R9
        open_reg <= 1'b0;
      end
      else
      begin
        shift_reg <= shift_next;
        bits_reg <= word_done ? '0 : bits_next;
        open_reg <= 1'b1;
      end
    end
  end

  // Trace packets: the first word is the address, the second the data.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      have_addr_reg <= 1'b0;
      pkt_addr_reg <= '0;
    end
    else if (fall && !s_sync)
    begin
      have_addr_reg <= 1'b0;
    end
    else if (word_done && mode == injector_pkg::MODE_TRACE)
    begin
      // The address arrives inside the packet.
      if (!have_addr_reg)
      begin
        pkt_addr_reg <= shift_next; // see R2
      end
      have_addr_reg <= !have_addr_reg;
    end
  end

  // Direct data: the address restarts at the base as a frame opens and steps per word the FIFO accepts.
  // Loading on the opening edge works even when the link clock rests between frames.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_ctr_reg <= '0;
    end
    else if (fall && s_sync && !open_reg)
    begin
      addr_ctr_reg <= base_addr; // see R3
    end
    else if (word_done && mode == injector_pkg::MODE_DIRECT && push_ready)
    begin
      addr_ctr_reg <= addr_ctr_reg + injector_pkg::ADDR_STEP; // see R3
    end
  end

  // Entry holds the path, the full 32-bit address and the data word.
  always_comb
  begin
    push_valid = 1'b0;
    push_data = {s_path, addr_ctr_reg, shift_next}; // see R1
    if (word_done)
    begin
      if (mode == injector_pkg::MODE_DIRECT)
      begin
        push_valid = 1'b1;
      end
      else if (have_addr_reg)
      begin
        push_valid = 1'b1;
        push_data = {s_path, pkt_addr_reg, shift_next}; // see R2
      end
    end
  end

  // Flags a word lost because the FIFO was full.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      overflow <= 1'b0;
    end
    else
    begin
      overflow <= push_valid && !push_ready;
    end
  end

  // Buffers words between the link and the memory bus.
  inject_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // The select bit stored with each word picks the loop path.
  assign main_wr_valid = pop_valid && (pop_data[EW-1] == injector_pkg::PATH_MAIN); // see R7
  assign sig_wr_valid = pop_valid && (pop_data[EW-1] == injector_pkg::PATH_SIGNAL); // see R8
  assign pop_ready = (pop_data[EW-1] == injector_pkg::PATH_SIGNAL) ? sig_wr_ready
                                                                     : main_wr_ready;
  // Write master address and data, straight from the FIFO storage.
  assign wr_addr = pop_data[EW-2:injector_pkg::WORD_W]; // see R1
  assign wr_data = pop_data[injector_pkg::WORD_W-1:0];
endmodule // data_injection_module
`default_nettype wire

// >>> design/injector_pkg.sv
// Shared constants and types for the external memory write injector link.
// Functional notes
// R1: Device writes anywhere in 4GB as bus master.
// R2: Trace mode: each packet carries its address.
// R3: Direct mode: consecutive addresses generated by device.
// R4: One, two, four or eight lanes, matched.
// R5: Each lane at most 100 Mbit/s.
// R6: Sample on falling link clock; change elsewhere.
// R7: Two loop paths share one pin set.
// R8: Select input routes port to one path.
// R9: Write only complete assembled words.
`default_nettype none
package injector_pkg;
  // Number of data lanes on the link.
  localparam int MAX_LANES = 8;
  // Width of an assembled word and of a memory address.
  localparam int WORD_W = 32;
  localparam int ADDR_W = 32;
  // Width of the bit counter that tracks word assembly.
  localparam int CNT_W = 6;
  // Bits in one complete word, at the counter's width.
  localparam logic [CNT_W-1:0] WORD_BITS = 6'h20;
  // Byte step between consecutive direct-mode words.
  localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0004;
  // Fastest lane bit rate allowed and the system clock rate.
  localparam int LANE_MAX_MBPS = 100;
  localparam int CLK_MHZ = 100;
  // Link clock period made by the source end, in ns, and its half period in clk cycles.
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC = (LINK_PERIOD_NS * CLK_MHZ) / 2000;
  // Divider counter width for the link clock.
  localparam int DIV_W = 8;

  // Lane width code carried on the configuration inputs.
  typedef enum logic [1:0] {
    LANES_1 = 2'b00,
    LANES_2 = 2'b01,
    LANES_4 = 2'b10,
    LANES_8 = 2'b11
  } lane_cfg_e;

  // Frame format: address-carrying packets or bare data.
  typedef enum logic {
    MODE_TRACE = 1'b0,
    MODE_DIRECT = 1'b1
  } inject_mode_e;

  // Destination of the shared port.
  typedef enum logic {
    PATH_MAIN = 1'b0,
    PATH_SIGNAL = 1'b1
  } inject_path_e;

  // Number of lanes in use for a width code.
  function automatic logic [CNT_W-1:0] lane_count(input lane_cfg_e cfg);
    logic [CNT_W-1:0] n;
    n = 6'h01;
    unique case (cfg)
      LANES_1: n = 6'h01;
      LANES_2: n = 6'h02;
      LANES_4: n = 6'h04;
      LANES_8: n = 6'h08;
    endcase
    return n;
  endfunction
endpackage
`default_nettype wire

// >>> design/injector_if.sv
// Link pins between the external data source and the injection module.
`default_nettype none
interface injector_if;
  // Link clock made by the source; sampled by the device.
  logic lclk;
  // Frame strobe, high for the whole frame.
  logic sync;
  // Data lanes; only the configured low lanes carry bits.
  logic [injector_pkg::MAX_LANES-1:0] data;
  // Path select: low for main configuration, high for signal processing.
  logic path_sel;

  // Documented device end: every pin is an input.
  modport device (
    input lclk,
    input sync,
    input data,
    input path_sel
  );

  // External source end: drives every pin.
  modport source (
    output lclk,
    output sync,
    output data,
    output path_sel
  );
endinterface
`default_nettype wire

// >>> design/injection_source.sv
// Source end: makes the link clock and sends words on the lanes.
`default_nettype none
module injection_source #(
  parameter int HALF_CYC = injector_pkg::LINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  injector_if.source link,
  input wire injector_pkg::lane_cfg_e lane_cfg,
  input wire logic path_sel_in,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [injector_pkg::WORD_W-1:0] s_data,
  input wire logic s_last,
  output logic busy
);
  // Link clock divider.
  logic [injector_pkg::DIV_W-1:0] div_reg;
  logic lclk_reg;
  logic rise;
  logic stall;
  // High while the divider may advance; the link clock rests low otherwise.
  logic run;
  // Transmit state.
  logic sync_reg;
  logic last_reg;
  logic path_reg;
  logic [injector_pkg::MAX_LANES-1:0] data_reg;
  logic [injector_pkg::WORD_W-1:0] shift_reg;
  logic [injector_pkg::CNT_W-1:0] left_reg;
  logic [injector_pkg::CNT_W-1:0] lanes;
  logic [injector_pkg::WORD_W-1:0] src;
  logic [injector_pkg::MAX_LANES-1:0] chunk;

  // Frame start and word fetch happen only at a rising link edge.
  assign lanes = injector_pkg::lane_count(lane_cfg); // see R4
  // Clock waits when a frame runs dry between words.
  assign stall = sync_reg && !last_reg && (left_reg == '0) && !s_valid;
  // Clock runs only inside a frame, for a waiting word, or to finish a high half.
  // The high half after the closing edge gives the far end a falling edge with sync low.
  assign run = (sync_reg || lclk_reg || s_valid) && !(stall && !lclk_reg); // see R6
  assign rise = !lclk_reg && run &&
                (div_reg == injector_pkg::DIV_W'(HALF_CYC - 1)); // see R5
  assign s_ready = rise && (left_reg == '0) && !(sync_reg && last_reg);
  assign src = (left_reg == '0) ? s_data : shift_reg;
  assign busy = sync_reg;

  // Takes the top bits of the word for the configured lanes.
  always_comb
  begin
    chunk = '0;
    unique case (lane_cfg)
      injector_pkg::LANES_1: chunk = {7'h00, src[31]};
      injector_pkg::LANES_2: chunk = {6'h00, src[31:30]};
      injector_pkg::LANES_4: chunk = {4'h0, src[31:28]};
      injector_pkg::LANES_8: chunk = src[31:24];
    endcase
  end

  // Divides clk down to the link clock; never faster than the lane limit.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_reg <= '0;
      lclk_reg <= 1'b0;
    end
    else if (run)
    begin
      if (div_reg == injector_pkg::DIV_W'(HALF_CYC - 1))
      begin
        div_reg <= '0;
        lclk_reg <= !lclk_reg; // see R5
      end
      else
      begin
        div_reg <= div_reg + 1'b1;
      end
    end
  end

  // Lanes and sync change at the rising edge, away from the sampling edge.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      data_reg <= '0;
      shift_reg <= '0;
      left_reg <= '0;
    end
    else if (rise)
    begin
      if (left_reg != '0)
      begin
        // Next bits of the current word.
        data_reg <= chunk; // see R6
        shift_reg <= shift_reg << lanes;
        left_reg <= left_reg - lanes;
      end
      else if (s_ready && s_valid)
      begin
        // New word; opens a frame if none is open.
        sync_reg <= 1'b1; // see R6
        last_reg <= s_last;
        data_reg <= chunk;
        shift_reg <= s_data << lanes;
        left_reg <= injector_pkg::WORD_BITS - lanes;
      end
      else if (sync_reg && last_reg)
      begin
        // The last word has gone; close the frame.
        sync_reg <= 1'b0;
        last_reg <= 1'b0;
        data_reg <= '0;
      end
    end
  end

  // The destination is held still for the whole frame.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      path_reg <= 1'b0;
    end
    else if (!sync_reg)
    begin
      path_reg <= path_sel_in; // see R8
    end
  end

  assign link.lclk = lclk_reg;
  assign link.sync = sync_reg;
  assign link.data = data_reg;
  assign link.path_sel = path_reg;
endmodule // injection_source
`default_nettype wire

// >>> test/injector_props.sv
// Checker for the link pins between the source end and the injection module.
`default_nettype none
module injector_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic lclk,
  input wire logic sync,
  input wire logic [injector_pkg::MAX_LANES-1:0] data,
  input wire logic path_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles since the frame strobe went low, saturating at its top value.
  logic [3:0] idle_cnt_reg;

  // Counts idle cycles so the resting link clock can be checked.
  always_ff @(posedge clk)
  begin
    if (rst || sync)
      idle_cnt_reg <= 4'h0;
    else if (idle_cnt_reg != 4'hf)
      idle_cnt_reg <= idle_cnt_reg + 4'h1;
  end

  // All checks run on the system clock and rest during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sync_start_a: assert property ($rose(sync) |-> lclk)
    else $error("frame strobe rose without a link clock rise");
  data_stable_a: assert property (!$rose(lclk) |-> $stable(data))
    else $error("lanes changed away from a rising link clock");
  sync_stable_a: assert property (!$rose(lclk) |-> $stable(sync))
    else $error("frame strobe changed away from a rising link clock");
  rate_limit_a: assert property ($rose(lclk) |-> lclk [*4] ##1 !lclk)
    else $error("link clock high time is not four cycles");
  sel_stable_a: assert property (sync && $past(sync) |-> $stable(path_sel))
    else $error("path select moved inside a frame");
  idle_lanes_a: assert property (!sync |-> data == 8'h00)
    else $error("lanes not low outside a frame");
  idle_clock_a: assert property (!sync && idle_cnt_reg >= 4'h5 |-> !lclk)
    else $error("link clock running outside a frame");
  frame_gap_a: assert property ($fell(sync) |-> !sync [*8])
    else $error("frames closer than one link period");
endmodule // injector_props
`default_nettype wire

// >>> test/external_memory_write_injector_tb.sv
// Self-checking bench joining the source end to the injection module.
`default_nettype none
module external_memory_write_injector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and the run's counters.
  logic clk = 1'b0;
  logic rst = 1'b1;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int n_ovf = 0;
  int seed;
  // Lane width shared by both ends; mode and base address for the device, path for the source.
  injector_pkg::lane_cfg_e cfg = injector_pkg::LANES_1;
  injector_pkg::inject_mode_e mode = injector_pkg::MODE_DIRECT;
  logic sel = 1'b0;
  logic [31:0] base = 32'h0;
  // Source user side.
  logic s_valid = 1'b0;
  logic s_ready;
  logic [31:0] s_data = 32'h0;
  logic s_last = 1'b0;
  logic busy;
  // Memory write side; hold stalls both paths.
  logic hold = 1'b0;
  logic main_rdy = 1'b0;
  logic sig_rdy = 1'b0;
  logic main_v;
  logic sig_v;
  logic [31:0] wa;
  logic [31:0] wd;
  logic ovf;
  // Words to send, and expected writes as {path, address, data}.
  logic [31:0] tx_q[$];
  logic [64:0] exp_q[$];

  injector_if link();
  injection_source #(.HALF_CYC(4)) injection_source_inst (.clk(clk), .rst(rst), .link(link),
    .lane_cfg(cfg), .path_sel_in(sel), .s_valid(s_valid), .s_ready(s_ready),
    .s_data(s_data), .s_last(s_last), .busy(busy));
  data_injection_module #(.FIFO_DEPTH(8)) data_injection_module_inst (.clk(clk), .rst(rst),
    .link(link), .lane_cfg(cfg), .mode(mode), .base_addr(base), .main_wr_valid(main_v),
    .main_wr_ready(main_rdy), .sig_wr_valid(sig_v), .sig_wr_ready(sig_rdy), .wr_addr(wa),
    .wr_data(wd), .overflow(ovf));
  injector_props injector_props_inst (.clk(clk), .rst(rst), .lclk(link.lclk),
    .sync(link.sync), .data(link.data), .path_sel(link.path_sel));

  // Free-running system clock.
  always #5 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(input logic [64:0] seen, input logic [64:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] time %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end

  // Memory side stalls at random, or fully while hold is set.
  always @(posedge clk)
  begin
    main_rdy <= !hold && ($urandom % 4 != 0);
    sig_rdy <= !hold && ($urandom % 4 != 0);
  end

  // Each accepted write must be the model's next one, on the right path.
  always @(posedge clk)
  begin
    if (!rst && ovf === 1'b1)
      n_ovf = n_ovf + 1;
    if (!rst && ((main_v === 1'b1 && main_rdy) || (sig_v === 1'b1 && sig_rdy)))
    begin
      if (exp_q.size() == 0)
        check(65'h0, 65'h1);
      else
        check({sig_v, wa, wd}, exp_q.pop_front());
    end
  end

  // Sends the queued words as one frame, waits for its writes unless hold is set, then keeps the frame gap.
  task automatic send_frame();
    for (int i = 0; i < tx_q.size(); i++)
    begin
      s_valid <= 1'b1;
      s_data <= tx_q[i];
      s_last <= (i == tx_q.size() - 1);
      do @(posedge clk); while (s_ready !== 1'b1);
    end
    s_valid <= 1'b0;
    tx_q.delete();
    do @(posedge clk); while (busy !== 1'b0);
    while (!hold && exp_q.size() != 0) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask

  // Main sequence: direct frames, trace frames, then an overflow.
  initial
  begin
    seed = 32'hbd44b292;
    void'($urandom(seed));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    base <= $urandom & 32'hffff_fffc;
    @(posedge clk);
    // Direct frames at every lane width, each restarting at the base.
    for (int c = 0; c < 4; c++)
    begin
      cfg <= injector_pkg::lane_cfg_e'(c);
      for (int k = 0; k < 3; k++)
      begin
        tx_q.push_back($urandom);
        exp_q.push_back({1'b0, base + (32'(k) << 2), tx_q[k]});
      end
      send_frame();
    end
    $display("test direct done");
    // Trace frames on both paths; the odd trailing address word is dropped.
    mode <= injector_pkg::MODE_TRACE;
    for (int s = 0; s < 2; s++)
    begin
      sel <= s[0];
      cfg <= injector_pkg::lane_cfg_e'(2 * s + 1);
      for (int k = 0; k < 5; k++)
        tx_q.push_back($urandom);
      exp_q.push_back({s[0], tx_q[0], tx_q[1]});
      exp_q.push_back({s[0], tx_q[2], tx_q[3]});
      send_frame();
    end
    $display("test trace done");
    // Ten words into a stalled eight-deep buffer: two are refused.
    mode <= injector_pkg::MODE_DIRECT;
    hold <= 1'b1;
    check(65'(n_ovf), 65'h0);
    n_ovf = 0;
    for (int k = 0; k < 10; k++)
    begin
      tx_q.push_back($urandom);
      if (k < 8)
        exp_q.push_back({1'b1, base + (32'(k) << 2), tx_q[k]});
    end
    send_frame();
    check(65'(n_ovf), 65'h2);
    hold <= 1'b0;
    while (exp_q.size() != 0) @(posedge clk);
    $display("test overflow done");
    report_and_stop();
  end
endmodule // external_memory_write_injector_tb
`default_nettype wire
